/* logic/bitbang_port.sv */
`timescale 1ns/1ps
`include "bitbang_consts.svh"
module bitbang_port #(
  parameter int unsigned WAKE_CYCLES = 32'(`WAKE_CYCLES)
) (
  // clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // mode selection command
  input wire logic mode_cmd_valid,
  input wire logic [7:0] mode_cmd_code,
  input wire bitbang_pkg::pin_byte_t mode_cmd_mask,
  // baud generator tick
  input wire logic baud_tick,
  // host-to-device buffer
  input wire logic h2d_avail,
  input wire bitbang_pkg::pin_byte_t h2d_data,
  output logic h2d_pop,
  // device-to-host buffer
  input wire logic d2h_space,
  output logic d2h_push,
  output bitbang_pkg::pin_byte_t d2h_data,
  output logic d2h_flush,
  // parallel pins
  input wire bitbang_pkg::pin_byte_t pin_in,
  output bitbang_pkg::pin_byte_t pin_out,
  output bitbang_pkg::pin_byte_t pin_oe,
  output logic pin_sample_strobe_n,
  output logic pin_update_strobe_n,
  // flush and wake
  input wire logic flush_wake_n,
  input wire logic wake_pulldown_en,
  input wire logic suspended,
  output logic wake_request
);
  import bitbang_pkg::*;

  sync_if #(.W(8)) pins_sy ();
  sync_if #(.W(1)) wake_sy ();

  port_mode_t mode_q, mode_d;
  pin_byte_t dir_q, dir_d;
  pin_byte_t out_q, out_d;
  pin_byte_t sample_q, sample_d;
  pin_byte_t d2h_data_q, d2h_data_d;
  sync_state_t state_q, state_d;
  logic rd_n_q, rd_n_d;
  logic wr_n_q, wr_n_d;
  logic push_q, push_d;
  logic flush_q, flush_d;
  logic [1:0] settle_q, settle_d;
  logic wake_prev_q, wake_prev_d;
  logic wake_q, wake_d;
  logic wake_fired;
  logic wake_fall;
  logic async_take;
  logic sync_start;

  // external pins and the flush/wake line come from outside the clock domain
  pin_sync #(.W(8), .INIT(`PIN_IN_RESET)) u_pins_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .raw(pin_in),
    .sy(pins_sy)
  );

  pin_sync #(.W(1), .INIT(`WAKE_IN_RESET)) u_wake_sync (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .raw(flush_wake_n),
    .sy(wake_sy)
  );

  low_pulse_timer #(.CYCLES(WAKE_CYCLES)) u_wake_timer (
    .clk(clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .line(wake_sy),
    .fired(wake_fired)
  );

  // mode and direction mask come only from the selection command
  always_comb begin
    mode_d = mode_q;
    dir_d = dir_q;
    if (mode_cmd_valid) begin
      dir_d = mode_cmd_mask;
      case (mode_cmd_code)
        `MODE_CODE_ASYNC: mode_d = MODE_ASYNC;
        `MODE_CODE_SYNC: mode_d = MODE_SYNC;
        default: mode_d = MODE_OFF;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      mode_q <= MODE_OFF;
      dir_q <= `DIR_MASK_RESET;
    end else if (clk_en) begin
      mode_q <= mode_d;
      dir_q <= dir_d;
    end
  end

  // async takes a byte only when one waits and the baud tick fires
  assign async_take = (mode_q == MODE_ASYNC) && h2d_avail && baud_tick;
  // sync needs a byte, room for its sample and pins that show the last byte
  assign sync_start = (mode_q == MODE_SYNC) && h2d_avail && d2h_space && (settle_q == 2'h0);

  // pops are combinational so the buffer sees them in the same cycle
  always_comb begin
    h2d_pop = 1'b0;
    if (clk_en && !mode_cmd_valid) begin
      h2d_pop = async_take || (state_q == ST_APPLY && mode_q == MODE_SYNC);
    end
  end

  // port sequencer: strobes, output latch and sample path
  always_comb begin
    state_d = state_q;
    out_d = out_q;
    sample_d = sample_q;
    d2h_data_d = d2h_data_q;
    rd_n_d = 1'b1;
    wr_n_d = 1'b1;
    push_d = 1'b0;
    settle_d = (settle_q != 2'h0) ? settle_q - 2'h1 : 2'h0;
    if (mode_cmd_valid) begin
      // a new command aborts any access and parks the strobes high
      state_d = ST_IDLE;
    end else if (mode_q == MODE_ASYNC) begin
      state_d = ST_IDLE;
      if (async_take) begin
        out_d = h2d_data;
        wr_n_d = 1'b0;
      end
      // async reads pins on the baud tick, dropped when no space
      if (baud_tick && d2h_space && rd_n_q) begin
        sample_d = pins_sy.level;
        rd_n_d = 1'b0;
      end
      if (!rd_n_q) begin
        push_d = 1'b1;
        d2h_data_d = sample_q;
      end
    end else if (mode_q == MODE_SYNC) begin
      // read strobe rests active between bytes, so its only rise hands on a sample
      rd_n_d = rd_n_q;
      case (state_q)
        ST_IDLE: begin
          if (sync_start) begin
            sample_d = pins_sy.level;
            rd_n_d = 1'b0;
            state_d = ST_READ;
          end
        end
        ST_READ: begin
          // sample goes out as the read strobe rises
          push_d = 1'b1;
          rd_n_d = 1'b1;
          d2h_data_d = sample_q;
          state_d = ST_APPLY;
        end
        ST_APPLY: begin
          out_d = h2d_data;
          rd_n_d = 1'b0;
          state_d = ST_SETUP;
        end
        ST_SETUP: begin
          // two clocks of data setup before the write strobe falls
          settle_d = `SYNC_SETTLE_CYCLES;
          state_d = ST_WRITE;
        end
        ST_WRITE: begin
          wr_n_d = 1'b0;
          state_d = ST_IDLE;
        end
        default: begin
          state_d = ST_IDLE;
        end
      endcase
    end else begin
      state_d = ST_IDLE;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state_q <= ST_IDLE;
      out_q <= `PIN_OUT_RESET;
      sample_q <= `PIN_IN_RESET;
      d2h_data_q <= `PIN_IN_RESET;
      rd_n_q <= 1'b1;
      wr_n_q <= 1'b1;
      push_q <= 1'b0;
      settle_q <= 2'h0;
    end else if (clk_en) begin
      state_q <= state_d;
      out_q <= out_d;
      sample_q <= sample_d;
      d2h_data_q <= d2h_data_d;
      rd_n_q <= rd_n_d;
      wr_n_q <= wr_n_d;
      push_q <= push_d;
      settle_q <= settle_d;
    end
  end

  // flush on a falling edge unless the port is off, wake only after a long low and no pull-down
  assign wake_fall = wake_prev_q && !wake_sy.level[0];

  always_comb begin
    wake_prev_d = wake_sy.level[0];
    flush_d = wake_fall && (mode_q != MODE_OFF);
    wake_d = wake_fired && suspended && !wake_pulldown_en;
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wake_prev_q <= 1'b1;
      flush_q <= 1'b0;
      wake_q <= 1'b0;
    end else if (clk_en) begin
      wake_prev_q <= wake_prev_d;
      flush_q <= flush_d;
      wake_q <= wake_d;
    end
  end

  // only pins marked as outputs are driven; pin_out carries the whole written byte unmasked
  assign pin_oe = (mode_q == MODE_OFF) ? 8'h00 : dir_q;
  assign pin_out = out_q;
  assign pin_sample_strobe_n = rd_n_q;
  assign pin_update_strobe_n = wr_n_q;
  assign d2h_push = push_q;
  assign d2h_data = d2h_data_q;
  assign d2h_flush = flush_q;
  assign wake_request = wake_q;

  property p_rd_rise_push;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      ($rose(pin_sample_strobe_n) && !$past(mode_cmd_valid)) |-> d2h_push;
  endproperty
  a_rd_rise_push: assert property (p_rd_rise_push)
    else $error("read strobe rose without a sample push");

  property p_sync_order;
    @(posedge clk) disable iff (!rst_n || !clk_en || mode_cmd_valid)
      (h2d_pop && mode_q == MODE_SYNC) |=> !pin_sample_strobe_n && pin_out == $past(h2d_data)
        ##1 !pin_sample_strobe_n && pin_update_strobe_n ##1 !pin_update_strobe_n
        ##1 pin_update_strobe_n;
  endproperty
  a_sync_order: assert property (p_sync_order)
    else $error("sync strobe order broken");

  property p_sync_hold;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      (mode_q == MODE_SYNC && !h2d_pop && !mode_cmd_valid) |=> $stable(pin_out);
  endproperty
  a_sync_hold: assert property (p_sync_hold)
    else $error("sync pins changed without a pop");

  property p_sync_push_with_write;
    @(posedge clk) disable iff (!rst_n || !clk_en || mode_cmd_valid)
      (d2h_push && mode_q == MODE_SYNC) |-> h2d_pop;
  endproperty
  a_sync_push_with_write: assert property (p_sync_push_with_write)
    else $error("sync sample returned without a write");

  property p_sync_lag;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      (d2h_push && mode_q == MODE_SYNC) |-> d2h_data == $past(pins_sy.level, 2);
  endproperty
  a_sync_lag: assert property (p_sync_lag)
    else $error("sync sample not taken before output update");

  property p_sync_space;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      (state_q == ST_READ) |-> $past(d2h_space);
  endproperty
  a_sync_space: assert property (p_sync_space)
    else $error("sync cycle started without buffer space");

  property p_async_hold;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      (mode_q == MODE_ASYNC && !(h2d_avail && baud_tick)) |=> $stable(pin_out);
  endproperty
  a_async_hold: assert property (p_async_hold)
    else $error("async pins changed without data and tick");

  property p_async_write;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      (h2d_pop && mode_q == MODE_ASYNC) |=> !pin_update_strobe_n && pin_out == $past(h2d_data)
        ##1 pin_update_strobe_n;
  endproperty
  a_async_write: assert property (p_async_write)
    else $error("async byte not applied with write strobe");

  property p_flush_edge;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      (wake_fall && mode_q != MODE_OFF) |=> d2h_flush;
  endproperty
  a_flush_edge: assert property (p_flush_edge)
    else $error("falling flush edge not flagged");

  property p_dir_hold;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      !mode_cmd_valid |=> $stable(dir_q);
  endproperty
  a_dir_hold: assert property (p_dir_hold)
    else $error("direction changed without a command");

  property p_mode_sel;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      (mode_cmd_valid && mode_cmd_code == `MODE_CODE_SYNC) |=> mode_q == MODE_SYNC;
  endproperty
  a_mode_sel: assert property (p_mode_sel)
    else $error("sync mode code not taken");

  property p_idle_strobes;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      (mode_q == MODE_OFF) |=> pin_sample_strobe_n && pin_update_strobe_n;
  endproperty
  a_idle_strobes: assert property (p_idle_strobes)
    else $error("strobe active while port is off");

  property p_wake_gate;
    @(posedge clk) disable iff (!rst_n || !clk_en)
      wake_request |-> !$past(wake_pulldown_en) && $past(suspended);
  endproperty
  a_wake_gate: assert property (p_wake_gate)
    else $error("wake raised with pull-down enabled");
endmodule

/* logic/bitbang_consts.svh */
`ifndef BITBANG_CONSTS_SVH
`define BITBANG_CONSTS_SVH

// mode codes carried by the bit-mode selection command
`define MODE_CODE_OFF 8'h00
`define MODE_CODE_ASYNC 8'h01
`define MODE_CODE_SYNC 8'h04

// reset values
`define DIR_MASK_RESET 8'h00
`define PIN_OUT_RESET 8'hFF
`define PIN_IN_RESET 8'hFF
`define WAKE_IN_RESET 1'b1

// timing: clock rate and the wake-up pulse length
`define CLK_MHZ 64'd250
`define WAKE_PULSE_NS 64'd20000000
`define WAKE_CYCLES ((`WAKE_PULSE_NS * `CLK_MHZ + 64'd999) / 64'd1000)
// idle clocks after a sync output change, so the synchroniser shows it
`define SYNC_SETTLE_CYCLES 2'h3

`endif

/* logic/bitbang_pkg.sv */
package bitbang_pkg;

  typedef logic [7:0] pin_byte_t;

  typedef enum logic [1:0] {
    MODE_OFF = 2'b00,
    MODE_ASYNC = 2'b01,
    MODE_SYNC = 2'b10
  } port_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_READ = 3'b001,
    ST_APPLY = 3'b010,
    ST_SETUP = 3'b011,
    ST_WRITE = 3'b100
  } sync_state_t;

endpackage

/* logic/sync_if.sv */
`timescale 1ns/1ps
// carries a filtered, synchronised level from a synchroniser to its users
interface sync_if #(
  parameter int W = 8
);
  logic [W-1:0] level;

  modport src (output level);
  modport dst (input level);
endinterface

/* logic/pin_sync.sv */
`timescale 1ns/1ps
module pin_sync #(
  parameter int W = 8,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // raw pins and clean level
  input wire logic [W-1:0] raw,
  sync_if.src sy
);
  logic [W-1:0] ff1_q, ff2_q, ff3_q, clean_q;
  logic [W-1:0] ff1_d, ff2_d, ff3_d, clean_d;

  // a bit only moves once the second and third stage agree
  always_comb begin
    ff1_d = raw;
    ff2_d = ff1_q;
    ff3_d = ff2_q;
    clean_d = (ff3_q & ~(ff2_q ^ ff3_q)) | (clean_q & (ff2_q ^ ff3_q));
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      ff1_q <= INIT;
      ff2_q <= INIT;
      ff3_q <= INIT;
      clean_q <= INIT;
    end else if (clk_en) begin
      ff1_q <= ff1_d;
      ff2_q <= ff2_d;
      ff3_q <= ff3_d;
      clean_q <= clean_d;
    end
  end

  assign sy.level = clean_q;
endmodule

/* logic/low_pulse_timer.sv */
`timescale 1ns/1ps
module low_pulse_timer #(
  parameter int unsigned CYCLES = 5000000
) (
  // clock and control
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clk_en,
  // watched line and result
  sync_if.dst line,
  output logic fired
);
  localparam int CW = $clog2(CYCLES + 1);
  logic [CW-1:0] cnt_q, cnt_d;
  logic fired_q, fired_d;

  // count low cycles, saturate, fire once when the length is reached
  always_comb begin
    cnt_d = cnt_q;
    fired_d = 1'b0;
    if (line.level[0]) begin
      cnt_d = '0;
    end else if (cnt_q != CW'(CYCLES)) begin
      cnt_d = cnt_q + CW'(1);
      fired_d = (cnt_q == CW'(CYCLES - 1));
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      cnt_q <= '0;
      fired_q <= 1'b0;
    end else if (clk_en) begin
      cnt_q <= cnt_d;
      fired_q <= fired_d;
    end
  end

  assign fired = fired_q;
endmodule

/* bench/pin_logic_model.sv */
`timescale 1ns/1ps
// outside logic on the port pins and on the flush/wake line
module pin_logic_model (
  // clock
  input wire logic clk,
  // pins as the outside world sees them
  input wire bitbang_pkg::pin_byte_t pin_out,
  input wire bitbang_pkg::pin_byte_t pin_oe,
  input wire bitbang_pkg::pin_byte_t ext_drive,
  output bitbang_pkg::pin_byte_t pin_in,
  // flush and wake line
  output logic flush_wake_n
);
  import bitbang_pkg::*;

  // driven bits follow the port, undriven bits follow outside logic
  assign pin_in = (pin_out & pin_oe) | (ext_drive & ~pin_oe);

  initial flush_wake_n = 1'b1;

  // low pulse of a given length in clocks, launched just after an edge
  task automatic pulse_low(input int cycles);
    @(posedge clk);
    #1 flush_wake_n = 1'b0;
    repeat (cycles) @(posedge clk);
    #1 flush_wake_n = 1'b1;
  endtask
endmodule

/* bench/usb_parallel_bit_bang_port_tb.sv */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin failures++; \
  $display("MISMATCH %s expected %0h seen %0h", nm, e, g); end end
module usb_parallel_bit_bang_port_tb;
  import bitbang_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, mode_cmd_valid = 1'b0, baud_tick = 1'b0;
  logic h2d_avail = 1'b0, d2h_space = 1'b1, wake_pulldown_en = 1'b0, suspended = 1'b0;
  logic [7:0] mode_cmd_code = 8'h00;
  pin_byte_t mode_cmd_mask = 8'h00, h2d_data = 8'h00, ext_drive = 8'h3C;
  pin_byte_t d2h_data, pin_in, pin_out, pin_oe;
  logic h2d_pop, d2h_push, d2h_flush, smp_n, upd_n, flush_wake_n, wake_request;
  logic fl, wk;
  int failures = 0, comparisons = 0, cycles = 0;

  bitbang_port #(.WAKE_CYCLES(20)) DUT (.clk(clk), .rst_n(rst_n), .clk_en(1'b1),
    .mode_cmd_valid(mode_cmd_valid), .mode_cmd_code(mode_cmd_code),
    .mode_cmd_mask(mode_cmd_mask), .baud_tick(baud_tick), .h2d_avail(h2d_avail),
    .h2d_data(h2d_data), .h2d_pop(h2d_pop), .d2h_space(d2h_space), .d2h_push(d2h_push),
    .d2h_data(d2h_data), .d2h_flush(d2h_flush), .pin_in(pin_in), .pin_out(pin_out),
    .pin_oe(pin_oe), .pin_sample_strobe_n(smp_n), .pin_update_strobe_n(upd_n),
    .flush_wake_n(flush_wake_n), .wake_pulldown_en(wake_pulldown_en),
    .suspended(suspended), .wake_request(wake_request));
  pin_logic_model M (.clk(clk), .pin_out(pin_out), .pin_oe(pin_oe),
    .ext_drive(ext_drive), .pin_in(pin_in), .flush_wake_n(flush_wake_n));

  // 250 MHz clock
  initial begin
    forever #2 clk = ~clk;
  end

  // hang guard, far above the expected run length
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      failures++;
      report_and_stop();
    end
  end

  task automatic report_and_stop();
    $display("comparisons %0d failures %0d", comparisons, failures);
    if (failures == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  // inputs always move 1 ns after the rising edge
  task automatic step(input int n = 1);
    repeat (n) begin
      @(posedge clk);
      #1;
    end
  endtask

  task automatic set_mode(input logic [7:0] code, input pin_byte_t mask);
    mode_cmd_valid = 1'b1;
    mode_cmd_code = code;
    mode_cmd_mask = mask;
    step();
    mode_cmd_valid = 1'b0;
    `CHK("pin_oe", (code == 8'h01 || code == 8'h04) ? mask : 8'h00, pin_oe)
  endtask

  // one sync byte: wait for its sample, then follow the strobe sequence
  task automatic sync_byte(input pin_byte_t d, input pin_byte_t exp);
    int n;
    n = 0;
    h2d_data = d;
    h2d_avail = 1'b1;
    while (d2h_push !== 1'b1 && n < 20) begin
      step();
      n++;
    end
    `CHK("sample", exp, d2h_data)
    `CHK("pop", 1'b1, h2d_pop)
    `CHK("smp_n rise", 1'b1, smp_n)
    step();
    h2d_avail = 1'b0;
    `CHK("pin_out", d, pin_out)
    `CHK("smp_n low", 1'b0, smp_n)
    step();
    `CHK("setup upd_n", 1'b1, upd_n)
    `CHK("setup smp_n", 1'b0, smp_n)
    step();
    `CHK("upd_n", 1'b0, upd_n)
    step();
    `CHK("upd_n end", 1'b1, upd_n)
  endtask

  task automatic pulse_and_watch(input int len);
    fork
      M.pulse_low(len);
      begin
        fl = 1'b0;
        wk = 1'b0;
        repeat (len + 20) begin
          step();
          fl |= d2h_flush;
          wk |= wake_request;
        end
      end
    join
  endtask

  task automatic t_async();
    pin_byte_t held;
    set_mode(8'h01, 8'hF0);
    h2d_data = 8'hA5;
    h2d_avail = 1'b1;
    held = pin_out;
    step(3);
    `CHK("no tick pop", 1'b0, h2d_pop)
    `CHK("no tick pins", held, pin_out)
    baud_tick = 1'b1;
    #1 `CHK("tick pop", 1'b1, h2d_pop)
    step();
    baud_tick = 1'b0;
    h2d_avail = 1'b0;
    `CHK("pin_out", 8'hA5, pin_out)
    `CHK("upd_n", 1'b0, upd_n)
    `CHK("smp_n", 1'b0, smp_n)
    step();
    `CHK("upd_n idle", 1'b1, upd_n)
    `CHK("push", 1'b1, d2h_push)
    step(6);
    baud_tick = 1'b1;
    step();
    baud_tick = 1'b0;
    `CHK("hold", 8'hA5, pin_out)
    step();
    `CHK("mixed pins", 8'hAC, d2h_data)
    $display("test async done");
  endtask

  task automatic t_sync();
    logic seen;
    logic rest;
    set_mode(8'h04, 8'h00);
    step(6);
    sync_byte(8'h77, 8'h3C);
    set_mode(8'h04, 8'hFF);
    step(6);
    sync_byte(8'h55, 8'h77);
    sync_byte(8'hAA, 8'h55);
    sync_byte(8'hAA, 8'hAA);
    d2h_space = 1'b0;
    h2d_avail = 1'b1;
    seen = 1'b0;
    rest = smp_n;
    repeat (8) begin
      step();
      seen |= d2h_push | h2d_pop | (smp_n ^ rest);
    end
    `CHK("no space", 1'b0, seen)
    h2d_avail = 1'b0;
    d2h_space = 1'b1;
    $display("test sync done");
  endtask

  task automatic t_flush_wake();
    pulse_and_watch(63);
    `CHK("flush", 1'b1, fl)
    suspended = 1'b1;
    pulse_and_watch(30);
    `CHK("wake", 1'b1, wk)
    wake_pulldown_en = 1'b1;
    pulse_and_watch(30);
    `CHK("pulldown wake", 1'b0, wk)
    set_mode(8'h00, 8'hFF);
    `CHK("strobes off", 2'b11, {smp_n, upd_n})
    $display("test flush and wake done");
  endtask

  initial begin
    step(4);
    rst_n = 1'b1;
    `CHK("reset strobes", 2'b11, {smp_n, upd_n})
    t_async();
    t_sync();
    t_flush_wake();
    report_and_stop();
  end
endmodule
